// File: mqws_cfg.svh
// Constants for the write-side queue selection block
`ifndef MQWS_CFG_SVH
`define MQWS_CFG_SVH

// ------------------------------------------------------------
// Address bus layout
// ------------------------------------------------------------
`define ADDR_W 8
`define QUEUE_MSB 4
`define QUEUE_LSB 0
`define DEV_MSB 7
`define DEV_LSB 5
`define DEV_ID_W 3
`define STAT_MSB 3
`define STAT_LSB 0
`define STAT_W 4

// ------------------------------------------------------------
// Queue, data and flag sizes
// ------------------------------------------------------------
`define QUEUES 32
`define DATA_W 36
`define FLAG_W 8
`define WORDS 4
`define WORD_IDX_W 2

// ------------------------------------------------------------
// Reset and idle values
// ------------------------------------------------------------
`define QUEUE_RST 5'h00
`define STAT_RST 4'h0
`define WORD_IDX_RST 2'h0
`define WORD_IDX_ONE 2'h1
`define FLAGS_IDLE 8'hff
`define STAT_HIGH_ZERO 2'h0

`endif

// File: mqws_pkg.sv
// Types and shared decoding for the write-side queue selection block
`include "mqws_cfg.svh"

package mqws_pkg;

    // Flag bus operating mode
    typedef enum logic
    {
        FLAG_DIRECT = 1'b0,
        FLAG_POLLED = 1'b1
    } flag_mode_e;

    typedef logic [`QUEUE_MSB:`QUEUE_LSB] queue_t;
    typedef logic [`DEV_ID_W-1:0] dev_id_t;
    typedef logic [`STAT_W-1:0] stat_sel_t;

    // True when this device owns the address on the bus
    function automatic logic device_match(input logic expansion, input dev_id_t own_id,
                                          input dev_id_t addr_id);
        device_match = !expansion || (addr_id == own_id);
    endfunction : device_match

endpackage : mqws_pkg

// File: wr_word_if.sv
// Carrier for enabled write words heading to the queue memory
`timescale 1ns/10ps

interface wr_word_if
    import mqws_pkg::*;
#(
    parameter int DATA_W = `DATA_W
);
    logic valid;
    logic ready;
    queue_t queue;
    logic [DATA_W-1:0] data;

    // Producer side
    modport src
    (
        output valid,
        output queue,
        output data,
        input ready
    );

    // Consumer side
    modport sink
    (
        input valid,
        input queue,
        input data,
        output ready
    );
endinterface : wr_word_if

// File: write_skid_buffer.sv
// Two-entry skid buffer between the write port and the queue memory
`timescale 1ns/10ps

module write_skid_buffer
    import mqws_pkg::*;
#(
    parameter int DATA_W = `DATA_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    wr_word_if.sink in_port,
    output logic out_valid_o,
    output queue_t out_queue_o,
    output logic [DATA_W-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic skid_valid;
    queue_t skid_queue;
    logic [DATA_W-1:0] skid_data;
    logic accept;
    logic next_skid_valid;
    logic ready;

    assign in_port.ready = ready;
    assign accept = in_port.valid && ready;

    // Skid slot fills when output is stalled
    always_comb
    begin
        next_skid_valid = skid_valid;
        if (skid_valid && out_ready_i)
            next_skid_valid = 1'b0;
        else if (accept && out_valid_o && !out_ready_i)
            next_skid_valid = 1'b1;
    end

    // Output stage
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            out_valid_o <= 1'b0;
            out_queue_o <= `QUEUE_RST;
            out_data_o <= '0;
        end
        else if (!out_valid_o || out_ready_i)
        begin
            out_valid_o <= skid_valid || accept;
            out_queue_o <= skid_valid ? skid_queue : in_port.queue;
            out_data_o <= skid_valid ? skid_data : in_port.data;
        end
    end

    // Skid stage
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            skid_valid <= 1'b0;
            skid_queue <= `QUEUE_RST;
            skid_data <= '0;
        end
        else
        begin
            skid_valid <= next_skid_valid;
            if (accept && out_valid_o && !out_ready_i)
            begin
                skid_queue <= in_port.queue;
                skid_data <= in_port.data;
            end
        end
    end

    // Registered ready, low while skid slot is taken
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ready <= 1'b1;
        else
            ready <= !next_skid_valid;
    end
endmodule : write_skid_buffer

// File: flag_status_mux.sv
// Almost-full status word selection and polling
`timescale 1ns/10ps

module flag_status_mux
    import mqws_pkg::*;
#(
    parameter int QUEUES = `QUEUES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire flag_mode_e mode_i,
    input wire logic select_i,
    input wire stat_sel_t sel_i,
    input wire logic [QUEUES-1:0] almost_full_i,
    output logic [`FLAG_W-1:0] flag_bus_n_o,
    output logic flag_sync_o
);
    logic [`FLAG_W-1:0] words [`WORDS];
    stat_sel_t sel;
    logic [`WORD_IDX_W-1:0] poll_idx;
    logic [`FLAG_W-1:0] next_word;

    // Status words, eight queues each
    for (genvar w = 0; w < `WORDS; w++)
    begin : g_word
        assign words[w] = almost_full_i[w*`FLAG_W +: `FLAG_W];
    end

    // Status word selector
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sel <= `STAT_RST;
        else if (select_i)
            sel <= sel_i; // RULE_09
    end

    // Polling index cycles every clock in polled mode, held at zero in direct mode, no write enable needed
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            poll_idx <= `WORD_IDX_RST;
        else if (mode_i == FLAG_POLLED)
            poll_idx <= poll_idx + `WORD_IDX_ONE; // RULE_12
        else
            poll_idx <= `WORD_IDX_RST;
    end

    // Word to show next
    always_comb
    begin
        next_word = `FLAGS_IDLE;
        if (mode_i == FLAG_POLLED)
            next_word = ~words[poll_idx];
        else if (sel[`STAT_MSB:`WORD_IDX_W] == `STAT_HIGH_ZERO)
            next_word = ~words[sel[`WORD_IDX_W-1:0]];
    end

    // Registered flag bus, active low
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flag_bus_n_o <= `FLAGS_IDLE;
            flag_sync_o <= 1'b0;
        end
        else
        begin
            flag_bus_n_o <= next_word;
            flag_sync_o <= (mode_i == FLAG_POLLED) && (poll_idx == `WORD_IDX_RST);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    status_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        select_i |=> (sel == $past(sel_i)))
        else $error("status word selector not captured");

    poll_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        (mode_i == FLAG_POLLED) ##1 (mode_i == FLAG_POLLED)
        |-> (poll_idx == $past(poll_idx) + `WORD_IDX_ONE))
        else $error("polled flag bus not cycling");
endmodule : flag_status_mux

// File: multi_queue_write_select.sv
// Write-side queue selection and write enable logic of a multi-queue FIFO
//
// Overview of operation
// RULE_01: Write only when write enable sampled low
// RULE_02: Address strobe high captures new write queue
// RULE_03: Queue selection ignores write enable level
// RULE_04: New queue written from second edge after
// RULE_05: Selection edge and next write old queue
// RULE_06: Eight-bit address bus, queue or status
// RULE_07: Low five bits pick one of 32
// RULE_08: Expansion: top three bits match device ID
// RULE_09: Flag strobe captures status selector, drives bus
// RULE_10: Bit four ignored in status selection
// RULE_11: Status selection edge still writes old queue
// RULE_12: Flag bus runs without any write enable
// RULE_13: Writer holds strobe until programming done
// RULE_14: Chip select acts as second write enable
// RULE_15: Writer supplies free-running write clock
// RULE_16: Writer never raises both strobes together
`timescale 1ns/10ps

module multi_queue_write_select
    import mqws_pkg::*;
#(
    parameter int DATA_W = `DATA_W,
    parameter int QUEUES = `QUEUES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic write_enable_n_i,
    input wire logic write_chip_select_n_i,
    input wire logic write_addr_strobe_i,
    input wire logic flag_status_strobe_i,
    input wire logic [`ADDR_W-1:0] write_queue_addr_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic expansion_mode_i,
    input wire dev_id_t device_id_i,
    input wire flag_mode_e flag_mode_i,
    input wire logic [QUEUES-1:0] queue_almost_full_i,
    input wire logic queue_write_ready_i,
    output logic write_ready_o,
    output logic queue_write_valid_o,
    output queue_t queue_write_sel_o,
    output logic [DATA_W-1:0] queue_write_data_o,
    output logic [`FLAG_W-1:0] almost_full_flag_bus_n_o,
    output logic flag_sync_o,
    output logic device_selected_o
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    queue_t addr_queue;
    dev_id_t addr_dev;
    stat_sel_t addr_stat;
    logic addr_match;
    logic queue_select;
    logic status_select;

    // Split the dual-purpose address bus
    assign addr_queue = write_queue_addr_i[`QUEUE_MSB:`QUEUE_LSB]; // RULE_07
    assign addr_dev = write_queue_addr_i[`DEV_MSB:`DEV_LSB]; // RULE_06
    assign addr_stat = write_queue_addr_i[`STAT_MSB:`STAT_LSB]; // RULE_10
    assign addr_match = device_match(expansion_mode_i, device_id_i, addr_dev); // RULE_08

    // Selection events, write enable not consulted
    assign queue_select = write_addr_strobe_i; // RULE_03
    assign status_select = flag_status_strobe_i && addr_match; // RULE_09

    // ------------------------------------------------------------
    // Queue selection pipeline
    // ------------------------------------------------------------
    logic pend_valid;
    queue_t pend_queue;
    logic pend_match;
    queue_t cur_queue;
    logic dev_active;

    // First stage holds the freshly strobed address
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pend_valid <= 1'b0;
            pend_queue <= `QUEUE_RST;
            pend_match <= 1'b0;
        end
        else
        begin
            pend_valid <= queue_select; // RULE_02
            if (queue_select)
            begin
                pend_queue <= addr_queue;
                pend_match <= addr_match;
            end
        end
    end

    // Second stage makes the selection current
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cur_queue <= `QUEUE_RST;
            dev_active <= 1'b1;
        end
        else if (pend_valid)
        begin
            cur_queue <= pend_queue; // RULE_04
            dev_active <= pend_match; // RULE_08
        end
    end

    // Selection flag for the outside world
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            device_selected_o <= 1'b1;
        else if (pend_valid)
            device_selected_o <= pend_match;
    end

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    wr_word_if #(.DATA_W(DATA_W)) wr ();
    logic write_req;
    logic push;

    // Both enables low, this device selected; current queue is the old one
    assign write_req = !write_enable_n_i && !write_chip_select_n_i && dev_active; // RULE_01 RULE_14
    assign wr.valid = write_req; // RULE_05 RULE_11
    assign wr.queue = cur_queue;
    assign wr.data = data_i;
    assign push = wr.valid && wr.ready;

    // Buffer absorbs stalls of the queue memory
    write_skid_buffer #(
        .DATA_W(DATA_W)
    ) u_buffer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_port(wr.sink),
        .out_valid_o(queue_write_valid_o),
        .out_queue_o(queue_write_sel_o),
        .out_data_o(queue_write_data_o),
        .out_ready_i(queue_write_ready_i)
    );

    // Ready toward the writer comes from a buffer flip-flop
    assign write_ready_o = wr.ready;

    // ------------------------------------------------------------
    // Flag status bus
    // ------------------------------------------------------------
    // Status word selected without any write enable
    flag_status_mux #(
        .QUEUES(QUEUES)
    ) u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(flag_mode_i),
        .select_i(status_select), // RULE_12
        .sel_i(addr_stat),
        .almost_full_i(queue_almost_full_i),
        .flag_bus_n_o(almost_full_flag_bus_n_o),
        .flag_sync_o(flag_sync_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    write_enable_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        write_enable_n_i |-> !push)
        else $error("write taken with write enable high");

    chip_select_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
        write_chip_select_n_i |-> !wr.valid)
        else $error("write taken with chip select high");

    queue_capture_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        (write_addr_strobe_i && addr_match)
        |-> ##2 (cur_queue == $past(write_queue_addr_i[`QUEUE_MSB:`QUEUE_LSB], 2)))
        else $error("strobed queue address not captured");

    select_no_enable_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        (write_addr_strobe_i && write_enable_n_i)
        |=> (pend_valid && (pend_queue == $past(write_queue_addr_i[`QUEUE_MSB:`QUEUE_LSB]))))
        else $error("selection depended on write enable");

    new_queue_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
        (write_addr_strobe_i && addr_match) ##2 push
        |-> (wr.queue == $past(write_queue_addr_i[`QUEUE_MSB:`QUEUE_LSB], 2)))
        else $error("new queue not written two edges after selection");

    old_queue_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        (write_addr_strobe_i && !pend_valid) |-> ##1 $stable(cur_queue))
        else $error("queue switched before second edge");

    device_id_match_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        (write_addr_strobe_i && expansion_mode_i && (addr_dev != device_id_i))
        |-> ##2 (!dev_active && !wr.valid))
        else $error("other device selection not honoured");

    status_edge_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
        (status_select && write_req && wr.ready) |-> (push && (wr.queue == cur_queue)))
        else $error("write lost on status selection edge");

    status_addr_bit_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        (status_select && write_queue_addr_i[`QUEUE_MSB])
        |=> (u_flags.sel == $past(write_queue_addr_i[`STAT_MSB:`STAT_LSB])))
        else $error("status selector uses wrong address bits");
endmodule : multi_queue_write_select

// File: upstream_writer.sv
// Behavioural model of the upstream writer feeding the write port
`timescale 1ns/10ps
`include "mqws_cfg.svh"

module upstream_writer
(
    input wire logic clk_i,
    input wire logic write_ready_i,
    input wire logic programmed_i,
    output logic write_enable_n_o,
    output logic write_chip_select_n_o,
    output logic write_addr_strobe_o,
    output logic flag_status_strobe_o,
    output logic [`ADDR_W-1:0] write_queue_addr_o,
    output logic [`DATA_W-1:0] data_o
);
    // ------------------------------------------------------------
    // Idle levels at time zero
    // ------------------------------------------------------------
    initial
    begin
        write_enable_n_o = 1'b1;
        write_chip_select_n_o = 1'b1;
        write_addr_strobe_o = 1'b0;
        flag_status_strobe_o = 1'b0;
        write_queue_addr_o = 8'h00;
        data_o = 36'h0_0000_0000;
    end

    // One request, launched just after an edge and held until taken or for at most 100 more edges
    task automatic drive(input logic we_n, input logic cs_n, input logic wstrb,
                         input logic fstrb, input logic [`ADDR_W-1:0] addr,
                         input logic [`DATA_W-1:0] d);
        int n;
        n = 0;
        write_enable_n_o <= we_n;
        write_chip_select_n_o <= cs_n;
        write_addr_strobe_o <= wstrb & programmed_i;
        flag_status_strobe_o <= fstrb & !wstrb;
        write_queue_addr_o <= addr;
        // Unused data bus toggles so stale words never look valid
        data_o <= (!we_n && !cs_n) ? d : ~data_o;
        @(posedge clk_i);
        // Hold the word while the buffer refuses it
        while (!we_n && !cs_n && !write_ready_i && n < 100)
        begin
            n++;
            @(posedge clk_i);
        end
    endtask : drive
endmodule : upstream_writer

// File: test_multi_queue_write_select.sv
// Self-checking testbench of the write-side queue selection block
`timescale 1ns/10ps
`include "mqws_cfg.svh"

module test_multi_queue_write_select;
    import mqws_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic expansion_mode_i = 1'b0;
    dev_id_t device_id_i = 3'h0;
    flag_mode_e flag_mode_i = FLAG_DIRECT;
    logic [31:0] queue_almost_full_i = 32'h8421_c3a5;
    logic queue_write_ready_i = 1'b1;
    logic programmed = 1'b0;
    logic we_n, cs_n, astb, fstb, write_ready_o, queue_write_valid_o;
    logic flag_sync_o, device_selected_o;
    logic [7:0] addr, almost_full_flag_bus_n_o;
    logic [35:0] data, queue_write_data_o;
    queue_t queue_write_sel_o;
    logic [40:0] got[$];
    logic [40:0] exp[$];
    int fail_count = 0;
    int samples_checked = 0;

    // ------------------------------------------------------------
    // Clock, writer model and design
    // ------------------------------------------------------------
    always #10 clk_i = ~clk_i;

    upstream_writer upstream_writer_i (.clk_i(clk_i), .write_ready_i(write_ready_o),
        .programmed_i(programmed), .write_enable_n_o(we_n), .write_chip_select_n_o(cs_n),
        .write_addr_strobe_o(astb), .flag_status_strobe_o(fstb),
        .write_queue_addr_o(addr), .data_o(data));

    multi_queue_write_select multi_queue_write_select_i (.clk_i(clk_i), .rst_i(rst_i),
        .write_enable_n_i(we_n), .write_chip_select_n_i(cs_n), .write_addr_strobe_i(astb),
        .flag_status_strobe_i(fstb), .write_queue_addr_i(addr), .data_i(data),
        .expansion_mode_i(expansion_mode_i), .device_id_i(device_id_i),
        .flag_mode_i(flag_mode_i), .queue_almost_full_i(queue_almost_full_i),
        .queue_write_ready_i(queue_write_ready_i), .write_ready_o(write_ready_o),
        .queue_write_valid_o(queue_write_valid_o), .queue_write_sel_o(queue_write_sel_o),
        .queue_write_data_o(queue_write_data_o),
        .almost_full_flag_bus_n_o(almost_full_flag_bus_n_o), .flag_sync_o(flag_sync_o),
        .device_selected_o(device_selected_o));

    // Record every word handed to the queue memory
    always @(posedge clk_i)
    begin
        if (!rst_i && queue_write_valid_o === 1'b1 && queue_write_ready_i)
            got.push_back({queue_write_sel_o, queue_write_data_o});
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
        samples_checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checked %0d values, %0d wrong", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic idle(input int n);
        repeat (n) upstream_writer_i.drive(1'b1, 1'b1, 1'b0, 1'b0, ~addr, 36'h0_0000_0000);
    endtask : idle

    task automatic wr(input queue_t q, input logic [35:0] d);
        exp.push_back({q, d});
        upstream_writer_i.drive(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, d);
    endtask : wr

    // Let the buffer empty, then compare words in order
    task automatic drain(input string name);
        queue_write_ready_i <= 1'b1;
        idle(6);
        check(64'(got.size()), 64'(exp.size()), "word count");
        foreach (exp[i])
            if (i < got.size())
                check(64'(got[i]), 64'(exp[i]), "queue and data");
        got.delete();
        exp.delete();
        $display("test %s done", name);
    endtask : drain

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_enables();
        wr(5'h00, 36'h1_0000_0001);
        upstream_writer_i.drive(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 36'h1_0000_0002);
        upstream_writer_i.drive(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 36'h1_0000_0003);
        wr(5'h00, 36'h1_0000_0004);
        drain("enables");
    endtask : t_enables

    task automatic t_select();
        exp.push_back({5'h00, 36'h2_0000_0011});
        upstream_writer_i.drive(1'b0, 1'b0, 1'b1, 1'b0, 8'h05, 36'h2_0000_0011);
        wr(5'h00, 36'h2_0000_0012);
        wr(5'h05, 36'h2_0000_0013);
        upstream_writer_i.drive(1'b1, 1'b0, 1'b1, 1'b0, 8'h1e, 36'h0_0000_0000);
        wr(5'h05, 36'h2_0000_0014);
        wr(5'h1e, 36'h2_0000_0015);
        drain("select");
    endtask : t_select

    task automatic t_expansion();
        expansion_mode_i <= 1'b1;
        device_id_i <= 3'h3;
        idle(2);
        upstream_writer_i.drive(1'b1, 1'b1, 1'b1, 1'b0, 8'h44, 36'h0_0000_0000);
        idle(1);
        upstream_writer_i.drive(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 36'h3_0000_0021);
        check(64'(device_selected_o), 64'h0, "other device");
        upstream_writer_i.drive(1'b1, 1'b1, 1'b1, 1'b0, 8'h67, 36'h0_0000_0000);
        idle(1);
        wr(5'h07, 36'h3_0000_0022);
        check(64'(device_selected_o), 64'h1, "own device");
        expansion_mode_i <= 1'b0;
        drain("expansion");
    endtask : t_expansion

    task automatic t_status();
        exp.push_back({5'h07, 36'h4_0000_0031});
        upstream_writer_i.drive(1'b0, 1'b0, 1'b0, 1'b1, 8'h11, 36'h4_0000_0031);
        idle(3);
        check(64'(almost_full_flag_bus_n_o), 64'h3c, "status word 1");
        upstream_writer_i.drive(1'b1, 1'b1, 1'b0, 1'b1, 8'h04, 36'h0_0000_0000);
        idle(3);
        check(64'(almost_full_flag_bus_n_o), 64'hff, "status word 4");
        drain("status");
    endtask : t_status

    task automatic t_polled();
        int seen;
        logic prev;
        seen = 0;
        prev = 1'b0;
        flag_mode_i <= FLAG_POLLED;
        idle(2);
        repeat (8)
        begin
            idle(1);
            if (prev)
                check(64'(almost_full_flag_bus_n_o), 64'h3c, "polled word 1");
            if (flag_sync_o === 1'b1)
            begin
                seen++;
                check(64'(almost_full_flag_bus_n_o), 64'h5a, "polled word 0");
            end
            prev = flag_sync_o;
        end
        check(64'(seen), 64'h2, "sync pulses");
        flag_mode_i <= FLAG_DIRECT;
        idle(2);
        $display("test polled done");
    endtask : t_polled

    task automatic t_stall();
        queue_write_ready_i <= 1'b0;
        fork
            begin
                repeat (7) @(posedge clk_i);
                check(64'(write_ready_o), 64'h0, "buffer full");
                queue_write_ready_i <= 1'b1;
            end
        join_none
        wr(5'h07, 36'h5_0000_0041);
        wr(5'h07, 36'h5_0000_0042);
        wr(5'h07, 36'h5_0000_0043);
        wr(5'h07, 36'h5_0000_0044);
        drain("stall");
        check(64'(write_ready_o), 64'h1, "buffer empty");
    endtask : t_stall

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        programmed <= 1'b1;
        @(posedge clk_i);
        t_enables();
        t_select();
        t_expansion();
        t_status();
        t_polled();
        t_stall();
        tally_and_finish();
    end

    initial
    begin
        #100000;
        fail_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : test_multi_queue_write_select
